// ==== spp_pkg.sv ====
// Shared constants for the parasite-powered sensor link: commands, timing and identity.
// Assumes a single 40 MHz clock shared by both ends and a synchronous active-high reset.
// Contract
// RQ1 - Master enables strong pullup within 10 us.
// RQ2 - Pullup held for conversion or 10 ms.
// RQ3 - No line activity while pullup enabled.
// RQ4 - Conversion finishes within 750 ms.
// RQ5 - Temperature result has 9-bit centigrade resolution.
// RQ6 - Unique 64-bit code selects each sensor.
// RQ7 - Sensor only pulls low or releases line.
// RQ8 - Alarm search answered only by alarmed sensors.
// RQ9 - Nonvolatile one-byte upper and lower limits.
// RQ10 - Convert command: measure, store, return idle.
// RQ11 - Copy command stores limits nonvolatile.
// RQ12 - Master releases pullup before further activity.
package spp_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned PULLUP_DLY_US  = 10;
  localparam int unsigned PULLUP_DLY_CYC = (PULLUP_DLY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CONV_MS        = 750;
  localparam int unsigned CONV_CYC       = CONV_MS * (CLK_HZ / 1000);
  localparam int unsigned NVWR_MS        = 10;
  localparam int unsigned NVWR_CYC       = NVWR_MS * (CLK_HZ / 1000);
  localparam logic [7:0]  CMD_CONVERT    = 8'h44;
  localparam logic [7:0]  CMD_COPY       = 8'h48;
  localparam logic [7:0]  CMD_WRITE_SP   = 8'h4e;
  localparam logic [7:0]  CMD_ALARM_SRCH = 8'hec;
  localparam logic [7:0]  CMD_MATCH      = 8'h55;
  localparam logic [15:0] TEMP_RST       = 16'h00aa;
  localparam logic [7:0]  FAMILY_CODE    = 8'h5a; // Arbitrary value.
  localparam int unsigned CNT_W          = 32;
endpackage

// ==== spp_if.sv ====
// Interface joining master and sensor over one open-drain data line.
// The line level is the wired-AND of both enables; the strong pullup enable does not enter it.
interface spp_if;
  logic m_dq_o;      // Master drive value (always 0 when driving).
  logic m_dq_oe_n;   // Master output enable, low while driving low.
  logic s_dq_o;      // Sensor drive value.
  logic s_dq_oe_n;   // Sensor output enable, low while driving low.
  logic strong_pu;   // Master strong pullup enable.
  logic m_cmd_vld;   // Master command byte strobe (transaction layer abstraction).
  logic [7:0]  m_cmd;   // Command byte.
  logic [63:0] m_rom;   // Code of sensor addressed with the command.
  logic [15:0] m_data;  // Limit bytes for write scratchpad {upper, lower}.
  logic s_resp;      // Sensor answers an alarm search, one-cycle pulse.
  logic dq;
  assign dq = (m_dq_oe_n | m_dq_o) & (s_dq_oe_n | s_dq_o);
  modport master (output m_dq_o, m_dq_oe_n, strong_pu, m_cmd_vld, m_cmd, m_rom, m_data,
                  input dq, s_resp);
  modport sensor (output s_dq_o, s_dq_oe_n, s_resp,
                  input dq, strong_pu, m_cmd_vld, m_cmd, m_rom, m_data);
endinterface

// ==== spp_sensor.sv ====
// Sensor end: command decode, conversion timer, limit storage and alarm search answer.
// Assumes commands arrive as already-framed bytes; the master keeps the pullup rules.
module spp_sensor #(
  parameter logic [47:0] SERIAL   = 48'h000000000001, // Arbitrary value.
  parameter int unsigned CONV_CYC = spp_pkg::CONV_CYC,
  parameter int unsigned NVWR_CYC = spp_pkg::NVWR_CYC
) (
  input  wire logic        i_mclk,   // Clock.
  input  wire logic        i_rst,    // Synchronous reset.
  input  wire logic [8:0]  i_temp,   // Sensed temperature, 0.5 C steps, two's complement.
  spp_if.sensor            bus,      // Link.
  output logic [15:0]      o_temp,   // Temperature register.
  output logic [7:0]       o_th,     // Stored upper limit.
  output logic [7:0]       o_tl,     // Stored lower limit.
  output logic             o_alarm,  // Alarm flag.
  output logic             o_busy    // Conversion or copy in progress.
);
  typedef enum logic [1:0] {SPP_IDLE, SPP_CONV, SPP_COPY} spp_st_t;
  spp_st_t st_reg, st_next;
  logic [spp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [15:0] temp_reg, temp_next, sp_reg, sp_next;
  logic [7:0]  th_reg, th_next, tl_reg, tl_next;
  logic        alarm_reg, alarm_next, resp_reg, resp_next;
  logic        busy_reg, busy_next;
  logic        sel;
  // Nonvolatile contents are modelled by registers with no reset of their value from the line.
  assign sel = (bus.m_rom == {8'h00, SERIAL, spp_pkg::FAMILY_CODE}); // [RQ6]
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    temp_next  = temp_reg;
    sp_next    = sp_reg;
    th_next    = th_reg;
    tl_next    = tl_reg;
    alarm_next = alarm_reg;
    resp_next  = 1'b0;
    unique case (st_reg)
      SPP_IDLE: begin
        if (bus.m_cmd_vld) begin
          if (bus.m_cmd == spp_pkg::CMD_ALARM_SRCH) begin
            resp_next = alarm_reg; // [RQ8]
          end else if (sel && bus.m_cmd == spp_pkg::CMD_CONVERT) begin
            st_next  = SPP_CONV; // [RQ10]
            cnt_next = '0;
          end else if (sel && bus.m_cmd == spp_pkg::CMD_COPY) begin
            st_next  = SPP_COPY; // [RQ11]
            cnt_next = '0;
          end else if (sel && bus.m_cmd == spp_pkg::CMD_WRITE_SP) begin
            sp_next = bus.m_data;
          end
        end
      end
      SPP_CONV: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CONV_CYC[spp_pkg::CNT_W-1:0] - 1'b1) begin // [RQ4]
          temp_next  = {{7{i_temp[8]}}, i_temp}; // [RQ5]
          alarm_next = ($signed(i_temp[8:1]) > $signed(th_reg)) ||
                       ($signed(i_temp[8:1]) < $signed(tl_reg));
          st_next    = SPP_IDLE;
        end
      end
      SPP_COPY: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == NVWR_CYC[spp_pkg::CNT_W-1:0] - 1'b1) begin
          th_next = sp_reg[15:8]; // [RQ9]
          tl_next = sp_reg[7:0];
          st_next = SPP_IDLE;
        end
      end
      default: st_next = SPP_IDLE;
    endcase
    busy_next = (st_next != SPP_IDLE);
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg    <= SPP_IDLE;
      cnt_reg   <= '0;
      temp_reg  <= spp_pkg::TEMP_RST;
      sp_reg    <= 16'h0000;
      alarm_reg <= 1'b0;
      resp_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      temp_reg  <= temp_next;
      sp_reg    <= sp_next;
      alarm_reg <= alarm_next;
      resp_reg  <= resp_next;
      busy_reg  <= busy_next;
    end
  end
  // Limits survive reset to stand in for EEPROM retention.
  always_ff @(posedge i_mclk) begin
    th_reg <= th_next;
    tl_reg <= tl_next;
  end
  assign bus.s_dq_o    = 1'b0;      // [RQ7]
  assign bus.s_dq_oe_n = ~resp_reg; // [RQ7]
  assign bus.s_resp    = resp_reg;
  assign o_temp  = temp_reg;
  assign o_th    = th_reg;
  assign o_tl    = tl_reg;
  assign o_alarm = alarm_reg;
  assign o_busy  = busy_reg;
endmodule

// ==== spp_master.sv ====
// Master end: sends a command, then for convert and copy holds the strong pullup for the operation's full time.
// Assumes one sensor operation at a time; a request while busy is ignored.
module spp_master #(
  parameter int unsigned CONV_CYC = spp_pkg::CONV_CYC,
  parameter int unsigned NVWR_CYC = spp_pkg::NVWR_CYC
) (
  input  wire logic        i_mclk,  // Clock.
  input  wire logic        i_rst,   // Synchronous reset.
  input  wire logic        i_req,   // Command request pulse.
  input  wire logic [7:0]  i_cmd,   // Command byte.
  input  wire logic [63:0] i_rom,   // Target sensor code.
  input  wire logic [15:0] i_data,  // Limit bytes.
  spp_if.master            bus,     // Link.
  output logic             o_busy,  // Strong pullup phase active.
  output logic             o_ack,   // Alarm response seen.
  output logic             o_done   // Operation finished, one-cycle pulse.
);
  typedef enum logic [1:0] {SPM_IDLE, SPM_GAP, SPM_HOLD} spp_mst_st_t;
  spp_mst_st_t st_reg, st_next;
  logic [spp_pkg::CNT_W-1:0] cnt_reg, cnt_next, len_reg, len_next;
  logic        vld_reg, vld_next, pu_reg, pu_next, done_reg, done_next, ack_reg, ack_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [63:0] rom_reg, rom_next;
  logic [15:0] dat_reg, dat_next;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    vld_next = 1'b0;
    pu_next = pu_reg;
    done_next = 1'b0;
    ack_next = bus.s_resp;
    cmd_next = cmd_reg;
    rom_next = rom_reg;
    dat_next = dat_reg;
    unique case (st_reg)
      SPM_IDLE: begin
        if (i_req) begin // [RQ3]
          vld_next = 1'b1;
          cmd_next = i_cmd;
          rom_next = i_rom;
          dat_next = i_data;
          if (i_cmd == spp_pkg::CMD_CONVERT || i_cmd == spp_pkg::CMD_COPY) begin
            st_next  = SPM_GAP;
            len_next = (i_cmd == spp_pkg::CMD_CONVERT) ? CONV_CYC[spp_pkg::CNT_W-1:0]
                                                       : NVWR_CYC[spp_pkg::CNT_W-1:0];
          end
        end
      end
      SPM_GAP: begin
        pu_next  = 1'b1; // [RQ1]
        cnt_next = '0;
        st_next  = SPM_HOLD;
      end
      SPM_HOLD: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == len_reg) begin // [RQ2]
          pu_next   = 1'b0; // [RQ12]
          done_next = 1'b1;
          st_next   = SPM_IDLE;
        end
      end
      default: st_next = SPM_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= SPM_IDLE;
      cnt_reg <= '0;
      len_reg <= '0;
      vld_reg <= 1'b0;
      pu_reg <= 1'b0;
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
      cmd_reg <= 8'h00;
      rom_reg <= 64'h0;
      dat_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      vld_reg <= vld_next;
      pu_reg <= pu_next;
      done_reg <= done_next;
      ack_reg <= ack_next;
      cmd_reg <= cmd_next;
      rom_reg <= rom_next;
      dat_reg <= dat_next;
    end
  end
  assign bus.m_dq_o    = 1'b0;
  assign bus.m_dq_oe_n = 1'b1; // No slot activity here; pullup phase keeps the line silent.
  assign bus.strong_pu = pu_reg;
  assign bus.m_cmd_vld = vld_reg;
  assign bus.m_cmd     = cmd_reg;
  assign bus.m_rom     = rom_reg;
  assign bus.m_data    = dat_reg;
  assign o_busy = pu_reg;
  assign o_ack  = ack_reg;
  assign o_done = done_reg;
endmodule

// ==== spp_checker.sv ====
// Checker for the pullup sequencing between the master and sensor ends.
// Assumes the interface signals are wired straight in and one clock domain.
module spp_checker #(
  parameter int unsigned CONV_CYC = spp_pkg::CONV_CYC,
  parameter int unsigned NVWR_CYC = spp_pkg::NVWR_CYC
) (
  input wire logic       i_mclk,     // Clock.
  input wire logic       i_rst,      // Synchronous reset.
  input wire logic       strong_pu,  // Strong pullup enable.
  input wire logic       m_cmd_vld,  // Command strobe.
  input wire logic [7:0] m_cmd,      // Command byte.
  input wire logic       s_resp,     // Sensor search answer.
  input wire logic       m_dq_oe_n,  // Master drive enable.
  input wire logic       s_dq_oe_n,  // Sensor drive enable.
  input wire logic       dq          // Line level.
);
  logic [31:0] pu_cnt_reg;
  logic [7:0]  last_cmd_reg;
  // The counter tells how long the pullup has stood, so hold time is judged per command.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pu_cnt_reg   <= 32'h0;
      last_cmd_reg <= 8'h00;
    end else begin
      pu_cnt_reg   <= strong_pu ? pu_cnt_reg + 32'h1 : 32'h0;
      last_cmd_reg <= m_cmd_vld ? m_cmd : last_cmd_reg;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  AST_PU_SOON: assert property (m_cmd_vld && (m_cmd == spp_pkg::CMD_CONVERT || m_cmd == spp_pkg::CMD_COPY)
    |=> strong_pu) else $error("pullup late");
  AST_PU_LEN: assert property ($fell(strong_pu) |->
    pu_cnt_reg == ((last_cmd_reg == spp_pkg::CMD_CONVERT) ? CONV_CYC + 1 : NVWR_CYC + 1))
    else $error("pullup length wrong");
  AST_CONV_MAX: assert property (strong_pu && last_cmd_reg == spp_pkg::CMD_CONVERT |->
    pu_cnt_reg <= CONV_CYC + 1) else $error("conversion too long");
  AST_QUIET: assert property (strong_pu |-> !m_cmd_vld && m_dq_oe_n && s_dq_oe_n)
    else $error("activity under pullup");
  AST_LINE_HI: assert property (strong_pu |-> dq) else $error("line low under pullup");
  AST_OPEN_DRAIN: assert property (!s_dq_oe_n |-> !dq) else $error("sensor drove high");
  AST_RESP: assert property (s_resp |-> $past(m_cmd_vld) && $past(m_cmd) == spp_pkg::CMD_ALARM_SRCH)
    else $error("answer without search");
  AST_RELEASE: assert property (m_cmd_vld |-> !$past(strong_pu)) else $error("command before release");
  AST_PU_CAUSE: assert property ($rose(strong_pu) |-> $past(m_cmd_vld, 1) || $past(m_cmd_vld, 2))
    else $error("pullup without command");
endmodule

// ==== parasite_power_pullup_sequencing_tb.sv ====
// Bench joining master and sensor ends; limits, conversions and alarm searches.
// Assumes shortened hold counts of 20 and 10 cycles.
module parasite_power_pullup_sequencing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  TH  = 8'h20;
  localparam logic [7:0]  TL  = 8'hf0;
  localparam logic [63:0] ROM = {8'h00, 48'h000000000001, spp_pkg::FAMILY_CODE};
  localparam int unsigned CONV_N = 20;
  localparam int unsigned NVWR_N = 10;
  logic [63:0] rom = ROM;
  logic [32:0] last_e;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, done, ack, busy, alarm, s_busy, ea;
  logic [7:0]  cmd = 8'h00, th, tl, ack_n = 8'h00;
  logic [8:0]  temp = 9'h000;
  logic [15:0] data = 16'h0000, o_temp;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h0df55bc4;
  int          num_errors = 0, checks_done = 0;
  spp_if bus ();
  always #12.5 clk = ~clk;
  spp_master #(.CONV_CYC(CONV_N), .NVWR_CYC(NVWR_N)) spp_master_inst (.i_mclk(clk), .i_rst(rst), .i_req(req),
    .i_cmd(cmd), .i_rom(rom), .i_data(data), .bus(bus.master), .o_busy(busy), .o_ack(ack), .o_done(done));
  spp_sensor #(.CONV_CYC(CONV_N), .NVWR_CYC(NVWR_N)) spp_sensor_inst (.i_mclk(clk), .i_rst(rst), .i_temp(temp),
    .bus(bus.sensor), .o_temp(o_temp), .o_th(th), .o_tl(tl), .o_alarm(alarm), .o_busy(s_busy));
  spp_checker #(.CONV_CYC(CONV_N), .NVWR_CYC(NVWR_N)) spp_checker_inst (.i_mclk(clk), .i_rst(rst),
    .strong_pu(bus.strong_pu), .m_cmd_vld(bus.m_cmd_vld), .m_cmd(bus.m_cmd), .s_resp(bus.s_resp),
    .m_dq_oe_n(bus.m_dq_oe_n), .s_dq_oe_n(bus.s_dq_oe_n), .dq(bus.dq));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk) begin req <= 1'b1; cmd <= c; data <= d; end
    @(posedge clk) req <= 1'b0;
    if (c == spp_pkg::CMD_CONVERT || c == spp_pkg::CMD_COPY) begin
      repeat (2) @(posedge clk);
      cmp("busy", 33'h1, {32'h0, busy});
      cmp("sensor busy", {32'h0, (rom === ROM)}, {32'h0, s_busy});
      while (done !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    end
    if (n == 100) cmp("done", 33'h1, 33'h0);
    repeat (4) @(posedge clk);
  endtask
  task automatic conv(input logic [8:0] t);
    ea = ($signed(t[8:1]) > $signed(TH)) || ($signed(t[8:1]) < $signed(TL));
    @(posedge clk) temp <= t;
    last_e = {{7{t[8]}}, t, TH, TL, ea};
    exp_q.push_back(last_e);
    send(spp_pkg::CMD_CONVERT, 16'h0000);
  endtask
  // Results are judged only when the master reports the end of an operation.
  always @(posedge clk) if (done === 1'b1) begin
    if (exp_q.size() == 0) cmp("state", 33'h0, 33'h1);
    else cmp("state", exp_q.pop_front(), {o_temp, th, tl, alarm});
  end
  always @(posedge clk) if (ack === 1'b1) ack_n <= ack_n + 8'h01;
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    send(spp_pkg::CMD_WRITE_SP, {TH, TL});
    exp_q.push_back({16'h00aa, TH, TL, 1'b0});
    send(spp_pkg::CMD_COPY, {TH, TL});
    $display("test copy ended");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      conv(seed[8:0]);
    end
    $display("test random conversions ended");
    // A convert aimed at another code must leave the stored result untouched.
    @(posedge clk) begin rom <= ROM ^ 64'h0000000000000100; temp <= ~temp; end
    exp_q.push_back(last_e);
    send(spp_pkg::CMD_CONVERT, 16'h0000);
    rom <= ROM;
    $display("test unselected code ended");
    conv(9'h010);
    send(spp_pkg::CMD_ALARM_SRCH, 16'h0000);
    cmp("ack", 33'h0, {25'h0, ack_n});
    conv(9'h0ff);
    send(spp_pkg::CMD_ALARM_SRCH, 16'h0000);
    cmp("ack", 33'h1, {25'h0, ack_n});
    conv(9'h1c0);
    send(spp_pkg::CMD_ALARM_SRCH, 16'h0000);
    cmp("ack", 33'h2, {25'h0, ack_n});
    $display("test alarm search ended");
    end_sim();
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule
